// >>> adcs_pkg.sv
// Constants for the converter sequencer and its calibration registers.
// Assumes a single 125 MHz clock; every pin input is synchronised inside.
// How it works
// - Offset trim: 16 bits, top two read zero
// - Offset bits binary weighted, MSB five percent
// - Larger offset code corrects positive input offset
// - Gain trim: 16 bits, 14-bit field, MSB 2.5%
// - Gain code scales input, larger for smaller span
// - Start by low start pin or software bit
// - Hold on start rise or write end
// - Begin at next master fall after 10 ns setup
// - Run 16.5 master periods, 17.5 if setup missed
// - Busy falls at end, result then readable
// - Busy falling edge clears software start bit
// - First start after power-up runs self-calibration
// - Twelve-bit result by successive approximation
// - Calibration select picks the accessible register set
// - Pointer resets to gain or offset, advances per access
// - Status bit 4 shows conversion or calibration busy
package adcs_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int REG_W    = 16;           // Bus and register width
	localparam int TRIM_W   = 14;           // Trim data field width
	localparam int RES_W    = 12;           // Conversion result width
	localparam int PTR_W    = 4;            // Calibration pointer width
	localparam int DAC_REGS = 8;            // Number of DAC trim registers

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;       // System clock period
	localparam int SETUP_NS      = 10;      // Start-to-master-fall setup
	localparam int SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_HALVES   = 33;      // 16.5 master periods in half periods
	localparam int CAL_PERIODS   = 64;      // Self-calibration length, master periods

	// ------------------------------------------------------------
	// Control register fields (write image)
	// ------------------------------------------------------------
	localparam int CTRL_SW_START     = 0;   // Software start bit
	localparam int CTRL_CAL_SELECT_LO = 1;  // Calibration select, low bit
	localparam int CTRL_CAL_SELECT_HI = 2;  // Calibration select, high bit
	localparam int CTRL_READ_TARGET_LO = 14; // Read target, low bit
	localparam int CTRL_READ_TARGET_HI = 15; // Read target, high bit
	localparam logic [REG_W-1:0] CTRL_RESET   = 16'h0000;
	localparam logic [REG_W-1:0] STATUS_KEEP  = 16'h3F28; // Control bits echoed in status

	// ------------------------------------------------------------
	// Status register fields
	// ------------------------------------------------------------
	localparam logic [REG_W-1:0] STATUS_ONES = 16'h00C0; // Bits 7 and 6 read one
	localparam int STAT_BUSY   = 4;         // Busy flag position
	localparam int STAT_CALSEL = 1;         // Calibration select, low position
	localparam int STAT_CALRUN = 0;         // Calibration running flag

	// ------------------------------------------------------------
	// Selections and pointer positions
	// ------------------------------------------------------------
	localparam logic [1:0] RD_RESULT = 2'h0; // Read the conversion result
	localparam logic [1:0] RD_CAL    = 2'h2; // Read calibration registers
	localparam logic [1:0] RD_STATUS = 2'h3; // Read the status register
	localparam logic [1:0] CAL_ALL   = 2'h0; // Gain, offset and eight DAC
	localparam logic [1:0] CAL_GO    = 2'h1; // Gain and offset
	localparam logic [1:0] CAL_OFF   = 2'h2; // Offset only
	localparam logic [1:0] CAL_GAIN  = 2'h3; // Gain only
	localparam logic [PTR_W-1:0] PTR_GAIN = 4'h0;
	localparam logic [PTR_W-1:0] PTR_OFF  = 4'h1;
	localparam logic [PTR_W-1:0] PTR_DAC0 = 4'h2;
	localparam logic [PTR_W-1:0] PTR_LAST = 4'h9;

	// Conversion sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV, ST_CAL} adcs_state_type;

endpackage

// >>> adcs_trim_mem.sv
// Small memory for the eight DAC trim words.
// Assumes writes and reads come from the sequencer on the same clock.
`timescale 1ns/1ps
module adcs_trim_mem #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic             clk,
	input  wire logic             ce,
	input  wire logic             wrEn,
	input  wire logic [AW-1:0]    addr,
	input  wire logic [WIDTH-1:0] wrData,
	output logic      [WIDTH-1:0] rdData
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [WIDTH-1:0] mem [DEPTH];          // Trim words, no reset needed

	// Write port and registered read port
	always_ff @(posedge clk) begin
		if (ce) begin
			if (wrEn) begin
				mem[addr] <= wrData;
			end
			rdData <= mem[addr];
		end
	end

endmodule

// >>> adcs_sar.sv
// Successive-approximation engine: one bit decision per master-clock fall.
// Assumes the comparator level is already synchronised to clk.
`timescale 1ns/1ps
module adcs_sar
	import adcs_pkg::*;
#(
	parameter int BITS = 12
) (
	input  wire logic            clk,
	input  wire logic            srst,
	input  wire logic            ce,
	input  wire logic            start,
	input  wire logic            step,
	input  wire logic            compIn,
	output logic      [BITS-1:0] dacCode,
	output logic      [BITS-1:0] result
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [BITS-1:0] trial_q;               // Trial code on the capacitor DAC
	logic [BITS-1:0] bitMask_q;             // Bit under test, one-hot
	logic            run_q;                 // Decisions still pending

	// Keep the tested bit only if the held sample is at or above the trial
	wire  [BITS-1:0] decided = compIn ? trial_q : (trial_q & ~bitMask_q);
	wire  [BITS-1:0] nextMask = bitMask_q >> 1;

	assign dacCode = trial_q;

	// Bit-by-bit search from the MSB down
	always_ff @(posedge clk) begin
		if (srst) begin
			trial_q   <= '0;
			bitMask_q <= '0;
			run_q     <= 1'b0;
			result    <= '0;
		end else if (ce) begin
			if (start) begin
				// Midscale first trial
				bitMask_q <= {1'b1, {(BITS-1){1'b0}}};
				trial_q   <= {1'b1, {(BITS-1){1'b0}}};
				run_q     <= 1'b1;
			end else if (run_q && step) begin
				trial_q   <= decided | nextMask;
				bitMask_q <= nextMask;
				run_q     <= (nextMask != '0);
				// Final decision lands here; earlier values are partial
				if (nextMask == '0) begin
					result <= decided;
				end
			end
		end
	end

endmodule

// >>> adcs_sequencer.sv
// Conversion sequencer, parallel bus registers and calibration trims.
// Assumes all pins are asynchronous to clk and synchronises each of them;
// the master clock pin is sampled as a level, clk being much faster.
`timescale 1ns/1ps
module adcs_sequencer
	import adcs_pkg::*;
#(
	parameter int                       CAL_LEN     = 64,       // Self-cal length, master periods
	parameter logic [adcs_pkg::TRIM_W-1:0] OFFSET_INIT = 14'h2000, // Offset trim after reset
	parameter logic [adcs_pkg::TRIM_W-1:0] GAIN_INIT   = 14'h2000  // Gain trim after reset
) (
	input  wire logic                       clk,
	input  wire logic                       srst,
	input  wire logic                       ce,
	input  wire logic                       conversion_start_n,
	input  wire logic                       master_clock_in,
	input  wire logic                       busCsN,
	input  wire logic                       busRdN,
	input  wire logic                       busWrN,
	input  wire logic                       busCalWrite,
	input  wire logic                       byteMode,
	input  wire logic                       high_byte_select,
	input  wire logic [adcs_pkg::REG_W-1:0] busDataIn,
	output logic      [adcs_pkg::REG_W-1:0] busDataOut,
	output logic                            busDataOe,
	input  wire logic                       compIn,
	output logic                            trackHold,
	output logic      [adcs_pkg::RES_W-1:0] dacCode,
	output logic      [adcs_pkg::TRIM_W-1:0] offsetTrim,
	output logic      [adcs_pkg::TRIM_W-1:0] gainTrim,
	output logic                            busy
);
	import adcs_pkg::*;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	localparam int NPIN = 8 + REG_W;        // Single-bit pins plus data lines
	logic [NPIN-1:0] pinMeta_q;             // First stage, read by second only
	logic [NPIN-1:0] pinSync_q;             // Second stage, safe to use
	logic [NPIN-1:0] pinPrev_q;             // Previous synced value, edge finding
	logic [1:0]      byteSync_q;            // Byte-mode pin, two stages

	wire  [NPIN-1:0] pinRaw = {busDataIn, conversion_start_n, master_clock_in, busCsN,
		busRdN, busWrN, busCalWrite, high_byte_select, compIn};

	// Two flops for every asynchronous pin, plus one for edges
	always_ff @(posedge clk) begin
		if (srst) begin
			pinMeta_q <= {{REG_W{1'b0}}, 8'hFF};
			pinSync_q <= {{REG_W{1'b0}}, 8'hFF};
			pinPrev_q <= {{REG_W{1'b0}}, 8'hFF};
			byteSync_q <= 2'b00;
		end else if (ce) begin
			byteSync_q <= {byteSync_q[0], byteMode};
			pinMeta_q <= pinRaw;
			pinSync_q <= pinMeta_q;
			pinPrev_q <= pinSync_q;
		end
	end

	// ------------------------------------------------------------
	// Decoded pin events
	// ------------------------------------------------------------
	wire [REG_W-1:0] dataS   = pinSync_q[NPIN-1:8];
	wire             startS  = pinSync_q[7];
	wire             mclkS   = pinSync_q[6];
	wire             csS     = ~pinSync_q[5];
	wire             rdS     = ~pinSync_q[4];
	wire             calWrS  = pinSync_q[2];
	wire             hiByteS = pinSync_q[1];
	wire             compS   = pinSync_q[0];
	wire             byteS   = byteSync_q[1];
	wire             startRise = startS & ~pinPrev_q[7];    // Pin start edge
	wire             mclkFall  = ~mclkS & pinPrev_q[6];
	wire             mclkEdge  = mclkS ^ pinPrev_q[6];
	// Strobes act at their rising edge, the end of the access
	wire             rdEnd   = pinSync_q[4] & ~pinPrev_q[4] & csS;
	wire             wrEnd   = pinSync_q[3] & ~pinPrev_q[3] & csS;

	// ------------------------------------------------------------
	// Registers and sequencer state
	// ------------------------------------------------------------
	adcs_state_type   state_q;              // Sequencer state
	logic [REG_W-1:0] ctrl_q;               // Control register image
	logic             calDone_q;            // Power-up calibration has run
	logic             late_q;               // Setup missed, wait one more fall
	logic [1:0]       setupCnt_q;           // Cycles since the start event
	logic [7:0]       halfCnt_q;            // Master half periods or cal periods
	logic [RES_W-1:0] result_q;             // Result seen by the host
	logic [TRIM_W-1:0] offset_q;            // Offset trim field
	logic [TRIM_W-1:0] gain_q;              // Gain trim field
	logic [PTR_W-1:0] ptr_q;                // Calibration register pointer
	logic [7:0]       lowByte_q;            // Low byte staged in byte mode
	logic [REG_W-1:0] rdData_q;             // Registered read data

	// ------------------------------------------------------------
	// Control field decode
	// ------------------------------------------------------------
	wire [1:0] calSel  = {ctrl_q[CTRL_CAL_SELECT_HI], ctrl_q[CTRL_CAL_SELECT_LO]};
	wire [1:0] rdTgt   = {ctrl_q[CTRL_READ_TARGET_HI], ctrl_q[CTRL_READ_TARGET_LO]};
	wire       idle    = (state_q == ST_IDLE);
	wire       calRun  = (state_q == ST_CAL);
	wire       ctrlWr  = wrEnd & ~calWrS;
	wire       calWr   = wrEnd & calWrS;
	wire       swStart = ctrlWr & dataS[CTRL_SW_START];   // Software start
	// Busy requests are dropped here, with no effect on the run
	wire       startEvt = idle & (startRise | swStart);

	// ------------------------------------------------------------
	// Calibration pointer decode
	// ------------------------------------------------------------
	// Offset alone starts at offset, every other set at gain
	wire [PTR_W-1:0] ptrFirst = (calSel == CAL_OFF) ? PTR_OFF : PTR_GAIN;
	// Access set per select code
	wire [PTR_W-1:0] ptrLast  = (calSel == CAL_ALL)  ? PTR_LAST :
	                            (calSel == CAL_GAIN) ? PTR_GAIN : PTR_OFF;
	wire [PTR_W-1:0] ptrNext  = (ptr_q == ptrLast) ? ptrFirst : ptr_q + 4'h1;
	// Byte mode moves on only after the high byte
	wire             fullAcc  = ~byteS | hiByteS;
	wire             calRdEnd = rdEnd & (rdTgt == RD_CAL) & fullAcc;
	wire             calWrEnd = calWr & fullAcc;
	wire [TRIM_W-1:0] calWrData = byteS ? {dataS[5:0], lowByte_q} : dataS[TRIM_W-1:0];
	wire             isDac    = (ptr_q >= PTR_DAC0);
	wire [PTR_W-1:0] dacIdx   = ptr_q - PTR_DAC0;
	wire [TRIM_W-1:0] memRd;

	// DAC trim words live in their own small memory
	adcs_trim_mem #(
		.WIDTH (TRIM_W),
		.DEPTH (DAC_REGS),
		.AW    (3)
	) uTrimMem (
		.clk    (clk),
		.ce     (ce),
		.wrEn   (calWrEnd & isDac),
		.addr   (dacIdx[2:0]),
		.wrData (calWrData),
		.rdData (memRd)
	);

	// ------------------------------------------------------------
	// Successive approximation engine
	// ------------------------------------------------------------
	wire             convBegin = (state_q == ST_WAIT) & mclkFall & ~late_q
	                             & (setupCnt_q >= 2'(SETUP_CYC));
	wire             convLateBegin = (state_q == ST_WAIT) & mclkFall & late_q;
	wire [RES_W-1:0] sarResult;

	adcs_sar #(
		.BITS (RES_W)
	) uSar (
		.clk     (clk),
		.srst    (srst),
		.ce      (ce),
		.start   (convBegin | convLateBegin),
		.step    (mclkFall & (state_q == ST_CONV)),
		.compIn  (compS),
		.dacCode (dacCode),
		.result  (sarResult)
	);

	// ------------------------------------------------------------
	// End conditions
	// ------------------------------------------------------------
	wire convDone = (state_q == ST_CONV) & mclkEdge
	                & (halfCnt_q == 8'(CONV_HALVES - 1));
	wire calDoneEvt = calRun & mclkFall & (halfCnt_q == 8'(CAL_LEN - 1));
	wire opDone   = convDone | calDoneEvt;

	// ------------------------------------------------------------
	// Sequencer state machine
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			state_q    <= ST_IDLE;
			calDone_q  <= 1'b0;
			late_q     <= 1'b0;
			setupCnt_q <= 2'h0;
			halfCnt_q  <= 8'h00;
		end else if (ce) begin
			unique case (state_q)
				ST_IDLE: begin
					setupCnt_q <= 2'h0;
					late_q     <= 1'b0;
					halfCnt_q  <= 8'h00;
					if (startEvt) begin
						// First start after reset calibrates instead
						state_q <= calDone_q ? ST_WAIT : ST_CAL;
					end
				end
				ST_WAIT: begin
					// Setup margin counted from the start edge
					if (setupCnt_q != 2'h3) begin
						setupCnt_q <= setupCnt_q + 2'h1;
					end
					if (convBegin | convLateBegin) begin
						state_q <= ST_CONV;
					end else if (mclkFall) begin
						// Margin missed: one extra master period
						late_q <= 1'b1;
					end
				end
				ST_CONV: begin
					// Half periods from the initiating fall
					if (convDone) begin
						state_q <= ST_IDLE;
					end else if (mclkEdge) begin
						halfCnt_q <= halfCnt_q + 8'h01;
					end
				end
				ST_CAL: begin
					// Self-calibration timed in master periods
					if (calDoneEvt) begin
						state_q   <= ST_IDLE;
						calDone_q <= 1'b1;
					end else if (mclkFall) begin
						halfCnt_q <= halfCnt_q + 8'h01;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Busy, hold and result
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			busy      <= 1'b0;
			trackHold <= 1'b0;
			result_q  <= '0;
		end else if (ce) begin
			if (startEvt) begin
				busy      <= 1'b1;
				trackHold <= 1'b1;             // Hold on start edge or write end
			end else if (opDone) begin
				busy      <= 1'b0;             // Busy falls at completion
				trackHold <= 1'b0;             // Back to track for the next sample
			end
			if (convDone) begin
				result_q <= sarResult;         // Same edge as busy fall
			end
		end
	end

	// ------------------------------------------------------------
	// Control register and software start bit
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= CTRL_RESET;
		end else if (ce) begin
			if (ctrlWr) begin
				// A write that lands with busy falling keeps its bit
				ctrl_q <= dataS;
			end else if (opDone) begin
				ctrl_q[CTRL_SW_START] <= 1'b0; // Busy fall clears the bit
			end
		end
	end

	// ------------------------------------------------------------
	// Calibration registers and pointer
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			offset_q  <= OFFSET_INIT;
			gain_q    <= GAIN_INIT;
			ptr_q     <= PTR_GAIN;
			lowByte_q <= 8'h00;
		end else if (ce) begin
			if (calWr & byteS & ~hiByteS) begin
				lowByte_q <= dataS[7:0];        // Low byte must come first
			end
			if (calWrEnd && ptr_q == PTR_GAIN) begin
				gain_q <= calWrData;            // Top two bits dropped
			end
			if (calWrEnd && ptr_q == PTR_OFF) begin
				offset_q <= calWrData;          // Top two bits dropped
			end
			if (ctrlWr) begin
				// Pointer restarts on any control write
				ptr_q <= (dataS[CTRL_CAL_SELECT_HI:CTRL_CAL_SELECT_LO] == CAL_OFF)
				         ? PTR_OFF : PTR_GAIN;
			end else if (calWrEnd | calRdEnd) begin
				ptr_q <= ptrNext;               // Wraps to first after the last
			end
		end
	end

	// Trim codes steer the analog offset and gain DACs; a larger offset
	// code cancels positive offset, a larger gain code stretches a small
	// span, binary weighted from the MSB
	assign offsetTrim = offset_q;
	assign gainTrim   = gain_q;

	// ------------------------------------------------------------
	// Read data selection
	// ------------------------------------------------------------
	wire [TRIM_W-1:0] calRdVal = (ptr_q == PTR_GAIN) ? gain_q :
	                             (ptr_q == PTR_OFF)  ? offset_q : memRd;
	// Fixed ones and zeros, echoed control bits and live flags
	wire [REG_W-1:0] statusVal = STATUS_ONES | (ctrl_q & STATUS_KEEP)
	                             | (REG_W'(busy) << STAT_BUSY)
	                             | (REG_W'(calSel) << STAT_CALSEL)
	                             | (REG_W'(calRun) << STAT_CALRUN);
	wire [REG_W-1:0] wordVal = (rdTgt == RD_STATUS) ? statusVal :
	                           (rdTgt == RD_CAL)    ? {2'b00, calRdVal} :
	                           {{(REG_W-RES_W){1'b0}}, result_q};
	wire [REG_W-1:0] laneVal = (byteS & hiByteS) ? {8'h00, wordVal[15:8]} :
	                           byteS ? {8'h00, wordVal[7:0]} : wordVal;

	// Read data from a flop; the host read strobe is far longer
	always_ff @(posedge clk) begin
		if (srst) begin
			rdData_q <= '0;
		end else if (ce) begin
			rdData_q <= laneVal;
		end
	end

	assign busDataOut = rdData_q;
	assign busDataOe  = csS & rdS;      // Drive only inside a selected read

endmodule

// >>> adcs_front.sv
// Far-side model: a master clock source and an ideal comparator.
// Assumes the sample is held from the rising edge of trackHold.
`timescale 1ns/1ps
module adcs_front #(
	parameter int MPER = 16 // Master period in clk cycles
) (
	input  wire logic        clk,
	input  wire logic [11:0] level,
	input  wire logic        trackHold,
	input  wire logic [11:0] dacCode,
	output logic             master_clock_in,
	output logic             compIn
);
	logic [11:0] held_q = 12'h000; // Sample kept while holding
	logic        hold_q = 1'b0;    // Last hold level
	int          cnt_q  = 0;       // Place in the master period
	logic [11:0] sample;           // Held value, new one at the hold edge
	// --------------------------------------------------
	// Master clock never pauses, even between conversions
	// --------------------------------------------------
	always_ff @(posedge clk) begin
		cnt_q  <= (cnt_q == MPER - 1) ? 0 : cnt_q + 1;
		hold_q <= trackHold;
		held_q <= sample;
	end
	// Capture at the hold edge itself so the first decision sees it
	assign sample = (trackHold && !hold_q) ? level : held_q;
	assign master_clock_in = (cnt_q < MPER / 2);
	assign compIn = (sample >= dacCode);
endmodule

// >>> adcs_seq_chk.sv
// Checker for busy, hold and bus read outputs of the sequencer.
// Sees only the top ports; bound below to each sequencer.
`timescale 1ns/1ps
module adcs_seq_chk #(
	parameter int MAX_RUN = 320 // Longest busy run in clk cycles
) (
	input wire logic                       clk,
	input wire logic                       srst,
	input wire logic                       busCsN,
	input wire logic                       busRdN,
	input wire logic                       busDataOe,
	input wire logic                       trackHold,
	input wire logic [adcs_pkg::RES_W-1:0] dacCode,
	input wire logic                       busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic [9:0] busyRun_q; // Cycles busy has stood so far
	// Counter instead of a long repetition, which tools unroll
	always_ff @(posedge clk) begin
		busyRun_q <= (srst || !busy) ? 10'h000 : busyRun_q + 10'h001;
	end
	hold_with_busy_a: assert property (busy |-> trackHold)
		else $error("hold low while busy");
	hold_start_a: assert property ($rose(trackHold) |-> $rose(busy))
		else $error("hold rose apart from busy");
	hold_release_a: assert property ($fell(busy) |-> !trackHold)
		else $error("hold kept after busy fell");
	busy_min_a: assert property ($rose(busy) |-> busy [*8])
		else $error("busy too short");
	busy_max_a: assert property (busyRun_q <= MAX_RUN)
		else $error("busy too long");
	dac_busy_a: assert property ($changed(dacCode) |-> busy || $past(busy))
		else $error("trial code moved while idle");
	oe_src_a: assert property ($rose(busDataOe) |-> !$past(busCsN, 2) && !$past(busRdN, 2))
		else $error("bus driven without read");
	oe_drop_a: assert property (busRdN [*4] |-> !busDataOe)
		else $error("bus still driven after read");
endmodule
bind adcs_sequencer adcs_seq_chk #(.MAX_RUN(320)) i_chk (.clk(clk), .srst(srst), .busCsN(busCsN),
	.busRdN(busRdN), .busDataOe(busDataOe), .trackHold(trackHold), .dacCode(dacCode), .busy(busy));

// >>> tb_top.sv
// Testbench: starts, conversions and trim access on the pin bus.
// Assumes one 125 MHz clock; the front model gives master clock and comparator.
`timescale 1ns/1ps
module tb_top;
	import adcs_pkg::*;
	logic clk = 1'b0, srst = 1'b1, startN = 1'b1, csN = 1'b1, rdN = 1'b1, wrN = 1'b1;
	logic calWr = 1'b0, ceOn = 1'b1, mclk, comp, oe, hold, busy;
	logic [REG_W-1:0] dIn = 16'h0000, dOut;
	logic [RES_W-1:0] level = 12'h000, dac;
	logic [TRIM_W-1:0] offT, gainT;
	int error_cnt = 0, checked = 0, cyc = 0, run;
	always #4 clk = ~clk;
	adcs_sequencer #(.CAL_LEN(4)) i_dut (.clk(clk), .srst(srst), .ce(ceOn),
		.conversion_start_n(startN), .master_clock_in(mclk), .busCsN(csN), .busRdN(rdN),
		.busWrN(wrN), .busCalWrite(calWr), .byteMode(1'b0), .high_byte_select(1'b0),
		.busDataIn(dIn), .busDataOut(dOut), .busDataOe(oe), .compIn(comp), .trackHold(hold),
		.dacCode(dac), .offsetTrim(offT), .gainTrim(gainT), .busy(busy));
	adcs_front #(.MPER(16)) i_front (.clk(clk), .level(level), .trackHold(hold),
		.dacCode(dac), .master_clock_in(mclk), .compIn(comp));
	task automatic results;
		$display("compares %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Chip select outlasts the strobe so the edge is seen selected
	task automatic wr(input logic [15:0] d, input logic cal);
		calWr <= cal;
		dIn <= d;
		csN <= 1'b0;
		wrN <= 1'b0;
		tick(4);
		wrN <= 1'b1;
		tick(1);
		csN <= 1'b1;
		tick(5);
	endtask
	task automatic rd(input string nm, input logic [15:0] exp);
		csN <= 1'b0;
		rdN <= 1'b0;
		tick(6);
		chk(nm, exp, dOut);
		rdN <= 1'b1;
		tick(1);
		csN <= 1'b1;
		tick(5);
	endtask
	task automatic pulse;
		startN <= 1'b0;
		tick(4);
		startN <= 1'b1;
		tick(1);
	endtask
	task automatic wait_idle;
		while (busy !== 1'b0) tick(1);
	endtask
	// Pin start, then count how long busy stands
	task automatic pin_conv(input logic [11:0] lvl);
		level <= lvl;
		tick(1);
		pulse();
		for (run = 0; run < 20 && busy !== 1'b1; run++) tick(1);
		for (run = 0; busy === 1'b1; run++) tick(1);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end
	initial begin
		tick(3);
		srst <= 1'b0;
		tick(1);
		chk("offset trim", 16'h2000, {2'b00, offT});
		chk("gain trim", 16'h2000, {2'b00, gainT});
		wr(16'hC000, 1'b0);
		rd("idle status", 16'h00C0);
		pulse();
		tick(5);
		rd("cal status", 16'h00D1);
		wait_idle();
		$display("test reset and self-cal done");
		pin_conv(12'hA5C);
		chk("busy span", 16'h0001, {15'h0, run >= 264 && run <= 300});
		wr(16'h0000, 1'b0);
		rd("pin result", 16'h0A5C);
		$display("test pin start done");
		level <= 12'h123;
		wr(16'h0001, 1'b0);
		wait_idle();
		rd("soft result", 16'h0123);
		tick(40);
		chk("no restart", 16'h0000, {15'h0, busy});
		$display("test soft start done");
		level <= 12'hFFF;
		pulse();
		tick(40);
		pulse();
		wr(16'h0001, 1'b0);
		wait_idle();
		tick(60);
		chk("start ignored", 16'h0000, {15'h0, busy});
		rd("busy result", 16'h0FFF);
		$display("test start while busy done");
		wr(16'h0002, 1'b0);
		wr(16'hFFFF, 1'b1);
		chk("gain write", 16'h3FFF, {2'b00, gainT});
		wr(16'h1234, 1'b1);
		chk("offset write", 16'h1234, {2'b00, offT});
		wr(16'h8004, 1'b0);
		rd("offset read", 16'h1234);
		wr(16'h8006, 1'b0);
		rd("gain read", 16'h3FFF);
		$display("test trims done");
		// A start pulse while frozen must never reach the sequencer
		ceOn <= 1'b0;
		pulse();
		tick(4);
		ceOn <= 1'b1;
		tick(8);
		chk("frozen start", 16'h0000, {14'h0, hold, busy});
		$display("test clock enable done");
		results();
	end
endmodule
